// file: bbf_host.sv
// Bus master that drives a boot block flash device through its pins.
`timescale 1ns/100ps
`default_nettype none
`include "bbf_host_map.svh"

// Operation
// R1: Boot block of 16384 bytes, top or bottom; host flags it lockable.
// R2: Two 8192-byte parameter blocks, never write protected.
// R3: One 98304-byte main block plus seven 131072-byte main blocks.
// R4: Each block erases alone; host addresses erase to one block.
// R5: Below lockout supply only reads, status, clear and identifier work.
// R6: With valid supply, writes and erases are allowed besides reads.
// R7: Device engine runs program and erase, reports through status.
// R8: Write cycle: reset high, select low, output enable high, strobe low.
// R9: Identifier via command or high voltage on A9; A0 picks code.
// R10: After reset release the device reads array without any command.
// R11: Read: strobe high, select low, output enable low, reset high.
// R12: Host writes read array command before array reads after writes.
// R13: Word mode data floats on output disable, standby, power-down.
// R14: Byte mode uses low eight lines only; upper lines stay floating.
// R15: Byte mode uses top data pin as lowest address bit.
// R16: Holding reset low floats outputs, resets engine, minimum current.
// R17: Top-boot decode: boot highest, parameters, then 96K main block.
// R18: Bottom-boot decode mirrors order, boot block lowest.
module bbf_host
  import bbf_host_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reqValid,
  input wire logic [2:0] reqOp,
  input wire logic [19:0] reqAddr,
  input wire logic [15:0] reqData,
  input wire logic byteMode,
  input wire logic topBoot,
  output logic reqReady,
  output logic rspValid,
  output logic [15:0] rspData,
  output logic [3:0] rspBlock,
  output logic rspLockable,
  output logic [18:0] flashAddr,
  output logic flashIdHighVolt,
  output logic flashResetPowerdown_n,
  output logic flashChipSel_n,
  output logic flashOutEn_n,
  output logic flashWrite_n,
  output logic flashByte_n,
  output logic [15:0] flashDqOut,
  output logic flashDqLowOe,
  output logic flashDqHighOe,
  output logic flashDq15Oe,
  input wire logic [15:0] flashDqIn
);
  // ******************************************************************
  // State
  // ******************************************************************
  typedef struct packed {
    bbf_state_t state;
    logic [7:0] count;
    logic arrayMode;
    logic pendRead;
    logic pendWake;
    logic byteSel;
    logic [15:0] wdata;
    logic reqReady;
    logic rspValid;
    logic [15:0] rspData;
    logic [3:0] rspBlock;
    logic rspLockable;
    logic [18:0] addr;
    logic idHv;
    logic rp_n;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic byte_n;
    logic [15:0] dqOut;
    logic dqLowOe;
    logic dqHighOe;
    logic dq15Oe;
  } bbf_host_state_t;

  bbf_host_state_t s_reg;
  bbf_host_state_t s_next;
  logic [15:0] dqSync1_reg;
  logic [15:0] dqSync2_reg;
  logic [3:0] decKind;
  logic decLock;

  bbf_block_decode uDecode (
    .wordAddr(reqAddr[19:1]),
    .topBoot(topBoot),
    .blockKind(decKind),
    .mainIndex(),
    .lockable(decLock)
  );

  // Data pins are asynchronous to clk; two stages before any use.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dqSync1_reg <= 16'h0000;
      dqSync2_reg <= 16'h0000;
    end else begin
      dqSync1_reg <= flashDqIn;
      dqSync2_reg <= dqSync1_reg;
    end
  end

  // ******************************************************************
  // Sequencer
  // ******************************************************************
  always_comb begin
    s_next = s_reg;
    s_next.rspValid = 1'b0;
    unique case (s_reg.state)
      BBF_ST_RESET: begin
        // Hold reset low, then wait for the device to wake.
        s_next.count = 8'(s_reg.count + 8'h01);
        if (s_reg.count == 8'(`BBF_CYC_RESET_LOW)) begin
          s_next.rp_n = 1'b1; // R10
        end
        if (s_reg.count == 8'(`BBF_CYC_RESET_LOW + `BBF_CYC_RESET_WAKE)) begin
          s_next.state = BBF_ST_IDLE;
          s_next.arrayMode = 1'b1; // R10
          s_next.reqReady = 1'b1;
          // Only a wake request is answered; power-on reset is not a request.
          s_next.rspValid = s_reg.pendWake;
          s_next.pendWake = 1'b0;
          s_next.count = 8'h00;
        end
      end
      BBF_ST_IDLE: begin
        if (reqValid) begin
          s_next.reqReady = 1'b0;
          s_next.count = 8'h00;
          s_next.byte_n = ~byteMode;
          s_next.rspBlock = decKind;
          s_next.rspLockable = decLock; // R1 R2
          s_next.addr = reqAddr[19:1];
          s_next.byteSel = reqAddr[0];
          s_next.idHv = 1'b0;
          unique case (reqOp)
            BBF_OP_READ: begin
              if (!s_reg.arrayMode) begin
                // Array reads need read array mode first.
                s_next.wdata = {8'h00, `BBF_CMD_READ_ARRAY}; // R12
                s_next.pendRead = 1'b1; // R12
                s_next.arrayMode = 1'b1;
                s_next.state = BBF_ST_WSETUP;
              end else begin
                s_next.state = BBF_ST_READ;
              end
            end
            BBF_OP_READ_ID: begin
              // Identifier by high voltage on A9; A0 picks the code.
              s_next.idHv = 1'b1; // R9
              s_next.state = BBF_ST_READ;
            end
            BBF_OP_WRITE: begin
              s_next.wdata = reqData;
              // Any command other than read array leaves array mode.
              s_next.arrayMode = (reqData[7:0] == `BBF_CMD_READ_ARRAY); // R12
              s_next.state = BBF_ST_WSETUP;
            end
            BBF_OP_POWER_DOWN: begin
              s_next.rp_n = 1'b0; // R16
              s_next.state = BBF_ST_SLEEP;
            end
            BBF_OP_WAKE: begin
              s_next.reqReady = 1'b1;
              s_next.rspValid = 1'b1;
            end
            default: begin
              s_next.reqReady = 1'b1;
              s_next.rspValid = 1'b1;
            end
          endcase
        end
      end
      BBF_ST_READ: begin
        // Select low, output enable low, strobe high, reset high.
        s_next.ce_n = 1'b0; // R11
        s_next.oe_n = 1'b0;
        s_next.we_n = 1'b1;
        s_next.dqLowOe = 1'b0;
        s_next.dqHighOe = 1'b0;
        // In byte mode the top data pin carries the byte select address.
        s_next.dq15Oe = s_reg.byte_n ? 1'b0 : 1'b1; // R15
        s_next.dqOut = {s_reg.byteSel, 15'h0000};
        s_next.count = 8'(s_reg.count + 8'h01);
        // Two extra cycles cover the data synchroniser.
        if (s_reg.count == 8'(`BBF_CYC_ACCESS + 2)) begin
          s_next.rspData = s_reg.byte_n ? dqSync2_reg : {8'h00, dqSync2_reg[7:0]}; // R14
          s_next.rspValid = 1'b1;
          s_next.state = BBF_ST_RECOVER;
          s_next.count = 8'h00;
          s_next.ce_n = 1'b1; // R13
          s_next.oe_n = 1'b1;
          s_next.dq15Oe = 1'b0;
        end
      end
      BBF_ST_WSETUP: begin
        // Address and data settle before the strobe falls.
        s_next.ce_n = 1'b0;
        s_next.oe_n = 1'b1; // R8
        s_next.dqOut = s_reg.byte_n ? s_reg.wdata : {s_reg.byteSel, 7'h00, s_reg.wdata[7:0]};
        s_next.dqLowOe = 1'b1;
        s_next.dqHighOe = s_reg.byte_n; // R14
        s_next.dq15Oe = 1'b1; // R15
        s_next.count = 8'(s_reg.count + 8'h01);
        if (s_reg.count == 8'(`BBF_CYC_SETUP)) begin
          s_next.we_n = 1'b0; // R8
          s_next.state = BBF_ST_WPULSE;
          s_next.count = 8'h00;
        end
      end
      BBF_ST_WPULSE: begin
        s_next.count = 8'(s_reg.count + 8'h01);
        if (s_reg.count == 8'(`BBF_CYC_WRITE_PULSE)) begin
          // Device latches on the rising strobe; data held one more clock cycle.
          s_next.we_n = 1'b1; // R8
          s_next.state = BBF_ST_RECOVER;
          s_next.count = 8'h00;
          // The inserted read array write is not the answer to the read.
          s_next.rspValid = ~s_reg.pendRead;
        end
      end
      BBF_ST_RECOVER: begin
        s_next.ce_n = 1'b1;
        s_next.dqLowOe = 1'b0;
        s_next.dqHighOe = 1'b0;
        s_next.dq15Oe = 1'b0;
        s_next.idHv = 1'b0;
        s_next.count = 8'(s_reg.count + 8'h01);
        if (s_reg.count == 8'(`BBF_CYC_RECOVER)) begin
          // A read held back by the read array write starts now.
          s_next.state = s_reg.pendRead ? BBF_ST_READ : BBF_ST_IDLE; // R12
          s_next.reqReady = ~s_reg.pendRead;
          s_next.pendRead = 1'b0;
          s_next.count = 8'h00;
        end
      end
      BBF_ST_SLEEP: begin
        // Only a wake request leaves deep power-down.
        if (!s_reg.reqReady && s_reg.count == 8'h00) begin
          s_next.reqReady = 1'b1;
          s_next.rspValid = 1'b1;
          s_next.count = 8'h01;
        end else if (reqValid && reqOp == BBF_OP_WAKE) begin
          s_next.reqReady = 1'b0;
          s_next.pendWake = 1'b1;
          s_next.state = BBF_ST_RESET;
          s_next.count = 8'h00;
        end
      end
      default: begin
        s_next.state = BBF_ST_RESET;
        s_next.count = 8'h00;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '{state: BBF_ST_RESET, rp_n: 1'b0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                 byte_n: 1'b1, default: '0}; // R16
    end else begin
      s_reg <= s_next;
    end
  end

  // ******************************************************************
  // Outputs
  // ******************************************************************
  assign reqReady = s_reg.reqReady;
  assign rspValid = s_reg.rspValid;
  assign rspData = s_reg.rspData;
  assign rspBlock = s_reg.rspBlock;
  assign rspLockable = s_reg.rspLockable;
  assign flashAddr = s_reg.addr;
  assign flashIdHighVolt = s_reg.idHv;
  assign flashResetPowerdown_n = s_reg.rp_n;
  assign flashChipSel_n = s_reg.ce_n;
  assign flashOutEn_n = s_reg.oe_n;
  assign flashWrite_n = s_reg.we_n;
  assign flashByte_n = s_reg.byte_n;
  assign flashDqOut = s_reg.dqOut;
  assign flashDqLowOe = s_reg.dqLowOe;
  assign flashDqHighOe = s_reg.dqHighOe;
  assign flashDq15Oe = s_reg.dq15Oe;
endmodule
`default_nettype wire

// file: bbf_host_map.svh
// Timing counts, block layout and command codes for the boot block flash host.
`ifndef BBF_HOST_MAP_SVH
`define BBF_HOST_MAP_SVH

// Bus cycle times in nanoseconds; counts are derived at 8 ns per clock.
`define BBF_CLK_PERIOD_NS 8
`define BBF_T_ACCESS_NS 120
`define BBF_T_WRITE_PULSE_NS 50
`define BBF_T_SETUP_NS 10
`define BBF_T_RECOVER_NS 30
`define BBF_T_RESET_LOW_NS 100
`define BBF_T_RESET_WAKE_NS 600
`define BBF_CYC_ACCESS ((`BBF_T_ACCESS_NS + `BBF_CLK_PERIOD_NS - 1) / `BBF_CLK_PERIOD_NS)
`define BBF_CYC_WRITE_PULSE ((`BBF_T_WRITE_PULSE_NS + `BBF_CLK_PERIOD_NS - 1) / `BBF_CLK_PERIOD_NS)
`define BBF_CYC_SETUP ((`BBF_T_SETUP_NS + `BBF_CLK_PERIOD_NS - 1) / `BBF_CLK_PERIOD_NS)
`define BBF_CYC_RECOVER ((`BBF_T_RECOVER_NS + `BBF_CLK_PERIOD_NS - 1) / `BBF_CLK_PERIOD_NS)
`define BBF_CYC_RESET_LOW ((`BBF_T_RESET_LOW_NS + `BBF_CLK_PERIOD_NS - 1) / `BBF_CLK_PERIOD_NS)
`define BBF_CYC_RESET_WAKE ((`BBF_T_RESET_WAKE_NS + `BBF_CLK_PERIOD_NS - 1) / `BBF_CLK_PERIOD_NS)

// Block sizes in bytes.
`define BBF_BOOT_BYTES 16384
`define BBF_PARAM_BYTES 8192
`define BBF_MAIN_SMALL_BYTES 98304
`define BBF_MAIN_BYTES 131072

// Word address boundaries, top-boot form (19-bit word address).
`define BBF_TOP_BOOT_BASE 19'h7E000
`define BBF_TOP_PARAM1_BASE 19'h7D000
`define BBF_TOP_PARAM0_BASE 19'h7C000
`define BBF_TOP_MAIN_SMALL_BASE 19'h70000
// Word address boundaries, bottom-boot form.
`define BBF_BOT_PARAM0_BASE 19'h02000
`define BBF_BOT_PARAM1_BASE 19'h03000
`define BBF_BOT_MAIN_SMALL_BASE 19'h04000
`define BBF_BOT_MAIN_BASE 19'h10000

// Command codes.
`define BBF_CMD_READ_ARRAY 8'hFF
`define BBF_CMD_READ_ID 8'h90

`endif

// file: bbf_host_pkg.sv
// Types shared by the boot block flash host.
`default_nettype none
package bbf_host_pkg;
  typedef enum logic [2:0] {
    BBF_OP_READ = 3'h0,
    BBF_OP_WRITE = 3'h1,
    BBF_OP_READ_ID = 3'h2,
    BBF_OP_POWER_DOWN = 3'h3,
    BBF_OP_WAKE = 3'h4
  } bbf_op_t;

  typedef enum logic [2:0] {
    BBF_ST_RESET = 3'h0,
    BBF_ST_IDLE = 3'h1,
    BBF_ST_READ = 3'h2,
    BBF_ST_WSETUP = 3'h3,
    BBF_ST_WPULSE = 3'h4,
    BBF_ST_RECOVER = 3'h5,
    BBF_ST_SLEEP = 3'h6
  } bbf_state_t;

  typedef enum logic [3:0] {
    BBF_BLK_BOOT = 4'h0,
    BBF_BLK_PARAM0 = 4'h1,
    BBF_BLK_PARAM1 = 4'h2,
    BBF_BLK_MAIN_SMALL = 4'h3,
    BBF_BLK_MAIN = 4'h4
  } bbf_block_t;
endpackage
`default_nettype wire

// file: bbf_block_decode.sv
// Address to erase block decoder for both boot placements.
`timescale 1ns/100ps
`default_nettype none
`include "bbf_host_map.svh"

module bbf_block_decode
  import bbf_host_pkg::*;
(
  input wire logic [18:0] wordAddr,
  input wire logic topBoot,
  output logic [3:0] blockKind,
  output logic [2:0] mainIndex,
  output logic lockable
);
  always_comb begin
    mainIndex = 3'h0;
    if (topBoot) begin
      if (wordAddr >= `BBF_TOP_BOOT_BASE) begin
        blockKind = BBF_BLK_BOOT; // R17
      end else if (wordAddr >= `BBF_TOP_PARAM1_BASE) begin
        blockKind = BBF_BLK_PARAM1;
      end else if (wordAddr >= `BBF_TOP_PARAM0_BASE) begin
        blockKind = BBF_BLK_PARAM0;
      end else if (wordAddr >= `BBF_TOP_MAIN_SMALL_BASE) begin
        blockKind = BBF_BLK_MAIN_SMALL;
      end else begin
        blockKind = BBF_BLK_MAIN;
        mainIndex = wordAddr[18:16]; // R3
      end
    end else begin
      if (wordAddr < `BBF_BOT_PARAM0_BASE) begin
        blockKind = BBF_BLK_BOOT; // R18
      end else if (wordAddr < `BBF_BOT_PARAM1_BASE) begin
        blockKind = BBF_BLK_PARAM0;
      end else if (wordAddr < `BBF_BOT_MAIN_SMALL_BASE) begin
        blockKind = BBF_BLK_PARAM1;
      end else if (wordAddr < `BBF_BOT_MAIN_BASE) begin
        blockKind = BBF_BLK_MAIN_SMALL;
      end else begin
        blockKind = BBF_BLK_MAIN;
        mainIndex = 3'(wordAddr[18:16] - 3'h1);
      end
    end
    // Only the boot block may be locked; parameter blocks never are.
    lockable = (blockKind == BBF_BLK_BOOT); // R1 R2
  end
endmodule
`default_nettype wire

// file: bbf_flash_model.sv
// Behavioural boot block flash device seen from its pins.
`timescale 1ns/100ps
`default_nettype none
// ****
// Device model
// ****
module bbf_flash_model #(
  // Identifier values are arbitrary.
  parameter logic [15:0] MFR_ID = 16'h00A5,
  parameter logic [15:0] DEV_ID = 16'h5A3C,
  // High when the program supply is above its lockout level.
  parameter logic SUPPLY_OK = 1'b1
) (
  input wire logic resetPowerdown_n,
  input wire logic chipSel_n,
  input wire logic outEn_n,
  input wire logic write_n,
  input wire logic byte_n,
  input wire logic idHighVolt,
  input wire logic [18:0] addr,
  input wire logic [15:0] dq,
  output logic [15:0] dqDrive
);
  logic [15:0] mem [16];
  logic arrayMode;
  logic reading;
  logic [15:0] word;
  // Address and data are taken on the rising strobe edge; the low byte selects the command.
  always @(posedge write_n or negedge resetPowerdown_n) begin
    if (!resetPowerdown_n) begin
      arrayMode <= 1'b1;
    end else if (!chipSel_n && dq[7:0] == 8'hFF) begin
      arrayMode <= 1'b1;
    end else if (!chipSel_n) begin
      arrayMode <= 1'b0;
      // Only the addressed location changes, and only with a valid supply.
      if (SUPPLY_OK) mem[addr[3:0]] <= dq;
    end
  end
  always_comb begin
    word = arrayMode ? mem[addr[3:0]] : 16'h0080;
    if (idHighVolt) word = addr[0] ? DEV_ID : MFR_ID;
    if (!byte_n && !idHighVolt && dq[15]) word[7:0] = word[15:8];
  end
  assign reading = resetPowerdown_n && !chipSel_n && !outEn_n && write_n;
  // Released lines show the inverse of the word, so a stale value never passes as data.
  assign dqDrive = {reading && byte_n ? word[15:8] : ~word[15:8],
    reading ? word[7:0] : ~word[7:0]};
endmodule
`default_nettype wire

// file: bbf_host_monitor.sv
// Pin protocol checker for the boot block flash host.
`timescale 1ns/100ps
`default_nettype none
// ****
// Checker
// ****
module bbf_host_monitor
  import bbf_host_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reqReady,
  input wire logic [18:0] flashAddr,
  input wire logic flashResetPowerdown_n,
  input wire logic flashChipSel_n,
  input wire logic flashOutEn_n,
  input wire logic flashWrite_n,
  input wire logic flashByte_n,
  input wire logic [15:0] flashDqOut,
  input wire logic flashDqLowOe,
  input wire logic flashDqHighOe,
  input wire logic flashDq15Oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  write_lines_a: assert property (
    !flashWrite_n |-> flashResetPowerdown_n && !flashChipSel_n && flashOutEn_n)
    else $error("write strobe outside a write cycle");
  read_lines_a: assert property (
    !flashOutEn_n |-> flashWrite_n && !flashChipSel_n && flashResetPowerdown_n)
    else $error("output enable outside a read cycle");
  no_contend_a: assert property (!flashOutEn_n |-> !flashDqLowOe && !flashDqHighOe)
    else $error("host drives data while device outputs");
  byte_upper_a: assert property (!flashByte_n |-> !flashDqHighOe)
    else $error("upper data lines driven in byte mode");
  byte_addr_a: assert property (!flashByte_n && !flashOutEn_n |-> flashDq15Oe)
    else $error("byte select not driven on top data pin");
  sleep_float_a: assert property (
    !flashResetPowerdown_n |-> flashChipSel_n && !flashDqLowOe && !flashDq15Oe)
    else $error("bus active during power-down");
  pulse_width_a: assert property ($fell(flashWrite_n) |-> (!flashWrite_n) [*7])
    else $error("write strobe too short");
  latch_hold_a: assert property (
    $rose(flashWrite_n) |-> $stable(flashDqOut) && $stable(flashAddr) && flashDqLowOe)
    else $error("address or data moved at strobe rise");
  wake_settle_a: assert property (
    $rose(flashResetPowerdown_n) |-> (!reqReady && flashChipSel_n) [*8])
    else $error("access too soon after power-down release");
endmodule
bind bbf_host bbf_host_monitor mon (.clk(clk), .rst_n(rst_n), .reqReady(reqReady),
  .flashAddr(flashAddr), .flashResetPowerdown_n(flashResetPowerdown_n),
  .flashChipSel_n(flashChipSel_n), .flashOutEn_n(flashOutEn_n), .flashWrite_n(flashWrite_n),
  .flashByte_n(flashByte_n), .flashDqOut(flashDqOut), .flashDqLowOe(flashDqLowOe),
  .flashDqHighOe(flashDqHighOe), .flashDq15Oe(flashDq15Oe));
`default_nettype wire

// file: tb_top.sv
// Self-checking testbench for the boot block flash host.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checksDone++; if ((g) !== (e)) begin nErrors++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, g, e); end end
// ****
// Testbench
// ****
module tb_top;
  import bbf_host_pkg::*;
  // Identifier values are arbitrary.
  localparam logic [15:0] MFR = 16'h00A5;
  localparam logic [15:0] DEV = 16'h5A3C;
  logic clk, rst_n, reqValid, byteMode, topBoot, reqReady, rspValid, rspLockable;
  logic flashIdHighVolt, flashResetPowerdown_n, flashChipSel_n, flashOutEn_n;
  logic flashWrite_n, flashByte_n, flashDqLowOe, flashDqHighOe, flashDq15Oe;
  logic [2:0] reqOp;
  logic [3:0] rspBlock;
  logic [18:0] flashAddr;
  logic [19:0] reqAddr;
  logic [15:0] reqData, rspData, flashDqOut, flashDqIn, modelDq;
  int nErrors = 0;
  int checksDone = 0;
  // Each line takes the host's value while the host enables it, else the device's.
  assign flashDqIn = {flashDq15Oe ? flashDqOut[15] : modelDq[15],
    flashDqHighOe ? flashDqOut[14:8] : modelDq[14:8],
    flashDqLowOe ? flashDqOut[7:0] : modelDq[7:0]};
  bbf_host uut (.clk(clk), .rst_n(rst_n), .reqValid(reqValid), .reqOp(reqOp),
    .reqAddr(reqAddr), .reqData(reqData), .byteMode(byteMode), .topBoot(topBoot),
    .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData), .rspBlock(rspBlock),
    .rspLockable(rspLockable), .flashAddr(flashAddr), .flashIdHighVolt(flashIdHighVolt),
    .flashResetPowerdown_n(flashResetPowerdown_n), .flashChipSel_n(flashChipSel_n),
    .flashOutEn_n(flashOutEn_n), .flashWrite_n(flashWrite_n), .flashByte_n(flashByte_n),
    .flashDqOut(flashDqOut), .flashDqLowOe(flashDqLowOe), .flashDqHighOe(flashDqHighOe),
    .flashDq15Oe(flashDq15Oe), .flashDqIn(flashDqIn));
  bbf_flash_model #(.MFR_ID(MFR), .DEV_ID(DEV)) model (
    .resetPowerdown_n(flashResetPowerdown_n), .chipSel_n(flashChipSel_n),
    .outEn_n(flashOutEn_n), .write_n(flashWrite_n), .byte_n(flashByte_n),
    .idHighVolt(flashIdHighVolt), .addr(flashAddr), .dq(flashDqIn), .dqDrive(modelDq));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task summarize;
    $display("errors %0d checks %0d", nErrors, checksDone);
    if (nErrors == 0 && checksDone > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Requests start 1 ns after an edge once reqReady is seen and are held for one edge.
  task req(input logic [2:0] op, input logic [19:0] a, input logic [15:0] d, input logic bm);
    int i;
    i = 0;
    // At least one edge passes, so reqValid never rises in the step that lowered it.
    do begin
      @(posedge clk);
      #1;
      i++;
    end while (reqReady !== 1'b1 && i < 500);
    reqOp = op;
    reqAddr = a;
    reqData = d;
    byteMode = bm;
    reqValid = 1'b1;
    @(posedge clk);
    #1;
    reqValid = 1'b0;
    while (rspValid !== 1'b1 && i < 1000) begin
      @(posedge clk);
      #1;
      i++;
    end
    if (rspValid !== 1'b1) begin
      nErrors++;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, rspValid, 1'b1);
      summarize();
    end
  endtask
  task t_write_read;
    req(BBF_OP_WRITE, 20'h00006, 16'h1234, 1'b0);
    req(BBF_OP_READ, 20'h00006, 16'h0000, 1'b0);
    `CHK(rspData, 16'h1234)
    req(BBF_OP_READ, 20'h00007, 16'h0000, 1'b1);
    `CHK(rspData, 16'h0012)
    req(BBF_OP_READ, 20'h00006, 16'h0000, 1'b1);
    `CHK(rspData, 16'h0034)
  endtask
  task t_ident;
    req(BBF_OP_READ_ID, 20'h00000, 16'h0000, 1'b0);
    `CHK(rspData, MFR)
    req(BBF_OP_READ_ID, 20'h00002, 16'h0000, 1'b0);
    `CHK(rspData, DEV)
    req(BBF_OP_READ_ID, 20'h00002, 16'h0000, 1'b1);
    `CHK(rspData, {8'h00, DEV[7:0]})
  endtask
  task t_block;
    // Packed as boot placement, block kind, byte address.
    logic [27:0] tbl [12];
    tbl = '{28'h10FFFFE, 28'h12FA000, 28'h11F9FFE, 28'h11F8000, 28'h13E0000, 28'h14DFFFE,
      28'h0000000, 28'h0003FFE, 28'h0104000, 28'h0206000, 28'h031FFFE, 28'h0420000};
    foreach (tbl[k]) begin
      topBoot = tbl[k][24];
      req(BBF_OP_READ, tbl[k][19:0], 16'h0000, 1'b0);
      `CHK(rspBlock, tbl[k][23:20])
      `CHK(rspLockable, tbl[k][23:20] == 4'h0)
    end
  endtask
  task t_sleep;
    req(BBF_OP_WAKE, 20'h00000, 16'h0000, 1'b0);
    req(3'h7, 20'h00000, 16'h0000, 1'b0);
    `CHK(flashChipSel_n, 1'b1)
    req(BBF_OP_WRITE, 20'h00008, 16'h5678, 1'b0);
    req(BBF_OP_POWER_DOWN, 20'h00000, 16'h0000, 1'b0);
    `CHK(flashResetPowerdown_n, 1'b0)
    req(BBF_OP_WAKE, 20'h00000, 16'h0000, 1'b0);
    req(BBF_OP_READ, 20'h00008, 16'h0000, 1'b0);
    `CHK(rspData, 16'h5678)
  endtask
  initial begin
    rst_n = 1'b0;
    reqValid = 1'b0;
    reqOp = 3'h0;
    reqAddr = 20'h00000;
    reqData = 16'h0000;
    byteMode = 1'b0;
    topBoot = 1'b1;
    repeat (2) @(posedge clk);
    `CHK(flashResetPowerdown_n, 1'b0)
    `CHK(flashChipSel_n, 1'b1)
    #1;
    rst_n = 1'b1;
    t_write_read();
    t_ident();
    t_block();
    t_sleep();
    summarize();
  end
endmodule
`default_nettype wire
